// File: design/rtcb_top.sv
/* rtcb_top: backup-domain calendar clock with prescaler, two alarms,
   wakeup timer, calibration output, backup words, backup SRAM and
   low-power exit logic, reached over classic wishbone.
   assumes all pins asynchronous to clk_i and slower than clk_i/4. */
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module rtcb_top import rtcb_pkg::*; (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [AW-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic xtal_clk_i,
  input logic rc_clk_i,
  input logic fast_external_oscillator_i,
  input logic ref_clk_i,
  input logic wakeup_pin_i,
  input logic external_reset_pin_n_i,
  input logic independent_watchdog_rst_i,
  input logic tamper_i,
  input logic timestamp_i,
  input logic voltage_detector_output_i,
  input logic usb_wake_i,
  input logic eth_wake_i,
  input logic on_battery_i,
  input logic [15:0] external_event_lines_i,
  output logic calib_o,
  output logic [1:0] alarm_evt_o,
  output logic wakeup_evt_o,
  output logic stop_exit_o,
  output logic standby_exit_o,
  output rtcb_mode_t mode_o
);
  // whole state of the block
  typedef struct packed {
    rtcb_pin_t s1; // first sync stage
    rtcb_pin_t s2; // second sync stage
    rtcb_pin_t pv; // previous s2, for edges
    logic [6:0] hdiv; // fast clock divider
    logic [6:0] apre; // async prescaler
    logic [12:0] spre; // sync prescaler
    logic [5:0] refc; // reference edge count
    rtcb_time_reg_t tm;
    rtcb_date_reg_t dt;
    rtcb_ctrl_reg_t ctrl;
    rtcb_pre_reg_t pre;
    rtcb_alrm_reg_t al1;
    rtcb_alrm_reg_t al0;
    logic [15:0] wut_rl; // wakeup reload
    logic [15:0] wut_cnt; // wakeup count
    logic [3:0] wdiv; // rtc clock divider
    logic [1:0] alf; // sticky alarm flags
    logic wutf; // sticky wakeup flag
    rtcb_mode_t mode;
    logic sram_ok; // sram contents retained
    logic sec; // calendar just advanced
    logic ack;
    logic [31:0] dat;
    logic calib;
    logic [1:0] alev;
    logic wuev;
    logic stop_x;
    logic stby_x;
  } rtcb_st_t;

  rtcb_st_t s_ff, nxt_s;
  rtcb_pin_t pin, rise, fall; // raw pins and edges
  logic [1:0] hit; // alarm comparator hits
  logic rtck, hse_tk, ck_apre, ck_spre, ref_tk, tick;
  logic c_min, c_hr, day_end, c_mon, c_yr;
  logic wck, wut_hit, evt_rtc, stop_src, stby_src;
  logic req, acc, wr;
  logic [3:0] wmask;
  logic [5:0] ref_lim;
  logic [31:0] wd, rdat;
  rtcb_stat_reg_t wst; // write data seen as status layout
  // backup memories, never reset
  logic [31:0] bkp_mem [BKP_WORDS];
  logic [31:0] sram [SRAM_WORDS];

  // bcd increment of one field
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap year on a bcd year 00..99
  function automatic logic leap(input logic [7:0] y);
    case (y[3:0])
      4'h0, 4'h4, 4'h8: leap = !y[4];
      4'h2, 4'h6: leap = y[4];
      default: leap = 1'b0;
    endcase
  endfunction

  // last day of a bcd month
  function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
    case (m)
      MON_FEB: days_in = leap(y) ? DAY_29 : DAY_28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = DAY_30;
      default: days_in = DAY_31;
    endcase
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // address decode of the backup words
  function automatic logic is_bkp(input logic [AW-1:0] a);
    is_bkp = a >= OFS_BKP && a < OFS_BKP_END;
  endfunction

  // word index in a memory window
  function automatic logic [AW-1:0] word_of(input logic [AW-1:0] a);
    word_of = a >> BYTE_BITS;
  endfunction

  assign pin = '{xtal: xtal_clk_i, rc: rc_clk_i, fast: fast_external_oscillator_i,
                 refc: ref_clk_i, wkp: wakeup_pin_i, rst_n: external_reset_pin_n_i,
                 wdg: independent_watchdog_rst_i, tamp: tamper_i, tstp: timestamp_i,
                 voltage_detector_output: voltage_detector_output_i, usb: usb_wake_i, eth: eth_wake_i,
                 vbat: on_battery_i, ext: external_event_lines_i};
  assign rise = s_ff.s2 & ~s_ff.pv;
  assign fall = ~s_ff.s2 & s_ff.pv;
  assign req = wb_cyc_i && wb_stb_i;
  assign acc = req && s_ff.ack; // write lands at the ack edge
  assign wr = acc && wb_we_i;

  // two alarm comparators
  generate
    for (genvar g = 0; g < 2; g++) begin : g_alm
      rtcb_alarm u_alm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sec_i(s_ff.sec),
        .en_i(s_ff.ctrl.alrm_en[g]),
        .tm_i(s_ff.tm),
        .dt_i(s_ff.dt),
        .al_i(g == 0 ? s_ff.al0 : s_ff.al1),
        .hit_o(hit[g])
      );
    end
  endgenerate

  // read mux, registered at request
  always_comb begin
    rdat = '0;
    case (wb_adr_i)
      OFS_TIME: rdat = s_ff.tm;
      OFS_DATE: rdat = s_ff.dt;
      OFS_CTRL: rdat = s_ff.ctrl;
      OFS_PRE: rdat = s_ff.pre;
      OFS_WUT: rdat = 32'(s_ff.wut_rl);
      OFS_STAT: rdat = rtcb_stat_reg_t'{rsv: '0, sram_ok: s_ff.sram_ok,
                   mode: s_ff.mode, wutf: s_ff.wutf, alf: s_ff.alf};
      OFS_ALR0: rdat = s_ff.al0;
      OFS_ALR1: rdat = s_ff.al1;
      OFS_PWR: rdat = 32'(s_ff.mode);
      default: begin
        if (is_bkp(wb_adr_i)) begin
          rdat = bkp_mem[5'(word_of(wb_adr_i - OFS_BKP))];
        end else if (wb_adr_i[SRAM_BIT] && s_ff.ctrl.sram_en) begin
          rdat = sram[10'(word_of(wb_adr_i))];
        end
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = pin;
    nxt_s.s2 = s_ff.s1;
    nxt_s.pv = s_ff.s2;
    // clock source, runs in every power mode
    hse_tk = 1'b0;
    if (rise.fast) begin
      nxt_s.hdiv = s_ff.hdiv + 7'h01;
      hse_tk = s_ff.hdiv == HSE_DIV_LAST;
    end
    case (s_ff.ctrl.clk_sel)
      CS_XTAL: rtck = rise.xtal;
      CS_RC: rtck = rise.rc;
      CS_FAST: rtck = hse_tk;
      default: rtck = 1'b0;
    endcase
    // 7 + 13 bit prescaler
    ck_apre = 1'b0;
    ck_spre = 1'b0;
    if (rtck) begin
      if (s_ff.apre == '0) begin
        nxt_s.apre = s_ff.pre.asy;
        ck_apre = 1'b1;
      end else begin
        nxt_s.apre = s_ff.apre - 7'h01;
      end
    end
    if (ck_apre) begin
      if (s_ff.spre == '0) begin
        nxt_s.spre = s_ff.pre.syn;
        ck_spre = !s_ff.ctrl.ref_en;
      end else begin
        nxt_s.spre = s_ff.spre - 13'h0001;
      end
    end
    // reference clock paces the second
    ref_tk = 1'b0;
    ref_lim = s_ff.ctrl.ref_60 ? REF_60 : REF_50;
    if (s_ff.ctrl.ref_en && rise.refc) begin
      if (s_ff.refc == ref_lim - 6'h01) begin
        nxt_s.refc = '0;
        ref_tk = 1'b1;
        nxt_s.apre = s_ff.pre.asy;
        nxt_s.spre = s_ff.pre.syn;
      end else begin
        nxt_s.refc = s_ff.refc + 6'h01;
      end
    end
    tick = ck_spre || ref_tk;
    nxt_s.sec = tick;
    nxt_s.calib = s_ff.ctrl.calib_en && s_ff.apre[CAL_BIT];
    // calendar carries
    c_min = tick && s_ff.tm.sc == 7'(SEC_MAX);
    c_hr = c_min && s_ff.tm.mn == 7'(SEC_MAX);
    day_end = c_hr && (s_ff.ctrl.fmt12 ? (s_ff.tm.pm && s_ff.tm.hr == 6'(HR12_TURN))
                                       : s_ff.tm.hr == 6'(HR24_MAX));
    c_mon = day_end && 8'(s_ff.dt.dt) == days_in(8'(s_ff.dt.mo), s_ff.dt.yr);
    c_yr = c_mon && s_ff.dt.mo == 5'(MON_MAX);
    if (tick) begin
      nxt_s.tm.sc = c_min ? '0 : 7'(bcd_inc(8'(s_ff.tm.sc)));
    end
    if (c_min) begin
      nxt_s.tm.mn = c_hr ? '0 : 7'(bcd_inc(8'(s_ff.tm.mn)));
    end
    if (c_hr) begin
      if (s_ff.ctrl.fmt12) begin
        // 12 hour: 11 to 12 flips half, 12 to 01
        nxt_s.tm.hr = s_ff.tm.hr == 6'(HR12_MAX) ? 6'(BCD_ONE)
                                               : 6'(bcd_inc(8'(s_ff.tm.hr)));
        if (s_ff.tm.hr == 6'(HR12_TURN)) begin
          nxt_s.tm.pm = !s_ff.tm.pm;
        end
      end else begin
        nxt_s.tm.hr = day_end ? '0 : 6'(bcd_inc(8'(s_ff.tm.hr)));
      end
    end
    if (day_end) begin
      nxt_s.dt.wd = s_ff.dt.wd == WD_MAX ? WD_MIN : s_ff.dt.wd + 3'h1;
      nxt_s.dt.dt = c_mon ? 6'(BCD_ONE) : 6'(bcd_inc(8'(s_ff.dt.dt)));
    end
    if (c_mon) begin
      nxt_s.dt.mo = c_yr ? 5'(BCD_ONE) : 5'(bcd_inc(8'(s_ff.dt.mo)));
    end
    if (c_yr) begin
      nxt_s.dt.yr = s_ff.dt.yr == YR_MAX ? BCD_ZERO : bcd_inc(s_ff.dt.yr);
    end
    // wakeup timer with selectable resolution
    if (rtck) begin
      nxt_s.wdiv = s_ff.wdiv + 4'h1;
    end
    case (s_ff.ctrl.wut_sel)
      WS_16: wmask = WDV_16;
      WS_8: wmask = WDV_8;
      WS_2: wmask = WDV_2;
      default: wmask = '0;
    endcase
    wck = s_ff.ctrl.wut_sel == WS_SEC ? tick
                                      : rtck && (s_ff.wdiv & wmask) == wmask;
    wut_hit = 1'b0;
    if (s_ff.ctrl.wut_en && wck) begin
      if (s_ff.wut_cnt == '0) begin
        nxt_s.wut_cnt = s_ff.wut_rl;
        wut_hit = 1'b1;
      end else begin
        nxt_s.wut_cnt = s_ff.wut_cnt - 16'h0001;
      end
    end
    // event pulses
    nxt_s.alev = hit;
    nxt_s.wuev = wut_hit;
    nxt_s.stop_x = 1'b0;
    nxt_s.stby_x = 1'b0;
    // bus: ack one cycle after request
    nxt_s.ack = req && !s_ff.ack;
    if (req && !s_ff.ack) begin
      nxt_s.dat = rdat;
    end
    wd = merge(rdat, wb_dat_i, wb_sel_i);
    wst = rtcb_stat_reg_t'(wd);
    if (wr) begin
      case (wb_adr_i)
        OFS_TIME: nxt_s.tm = rtcb_time_reg_t'(wd & TIME_MASK);
        OFS_DATE: nxt_s.dt = rtcb_date_reg_t'(wd & DATE_MASK);
        OFS_CTRL: nxt_s.ctrl = rtcb_ctrl_reg_t'(wd & CTRL_MASK);
        OFS_PRE: nxt_s.pre = rtcb_pre_reg_t'(wd & PRE_MASK);
        OFS_WUT: begin
          nxt_s.wut_rl = 16'(wd);
          nxt_s.wut_cnt = 16'(wd);
        end
        OFS_STAT: begin
          nxt_s.alf = s_ff.alf & ~wst.alf;
          nxt_s.wutf = s_ff.wutf && !wst.wutf;
        end
        OFS_ALR0: nxt_s.al0 = rtcb_alrm_reg_t'(wd & ALRM_MASK);
        OFS_ALR1: nxt_s.al1 = rtcb_alrm_reg_t'(wd & ALRM_MASK);
        OFS_PWR: begin
          if (rtcb_mode_t'(wd[1:0]) == MD_STBY) begin
            nxt_s.mode = MD_STBY;
            if (!s_ff.ctrl.sram_en) begin
              nxt_s.sram_ok = 1'b0;
            end
          end else if (rtcb_mode_t'(wd[1:0]) == MD_STOP) begin
            nxt_s.mode = MD_STOP;
          end else begin
            nxt_s.mode = MD_RUN;
          end
        end
        default: begin
          if (wb_adr_i[SRAM_BIT] && s_ff.ctrl.sram_en) begin
            nxt_s.sram_ok = 1'b1;
          end
        end
      endcase
    end
    // sticky flags: a new event beats the clear
    nxt_s.alf = nxt_s.alf | hit;
    nxt_s.wutf = nxt_s.wutf || wut_hit;
    // low-power exit
    evt_rtc = |hit || wut_hit || rise.tamp || rise.tstp;
    stop_src = |s_ff.s2.ext || s_ff.s2.voltage_detector_output || s_ff.s2.usb || s_ff.s2.eth
            || evt_rtc;
    stby_src = fall.rst_n || s_ff.s2.wdg || rise.wkp || evt_rtc;
    case (s_ff.mode)
      MD_STOP: begin
        if (stop_src && !s_ff.s2.vbat) begin
          nxt_s.mode = MD_RUN;
          nxt_s.stop_x = 1'b1;
        end
      end
      MD_STBY: begin
        if (stby_src && !s_ff.s2.vbat) begin
          nxt_s.mode = MD_RUN;
          nxt_s.stby_x = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.pre <= PRE_RST;
      s_ff.dt <= DATE_RST;
      s_ff.mode <= MD_RUN;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // memories keep contents through any reset
  always_ff @(posedge clk_i) begin
    if (wr && is_bkp(wb_adr_i)) begin
      bkp_mem[5'(word_of(wb_adr_i - OFS_BKP))] <= wd;
    end
    if (wr && wb_adr_i[SRAM_BIT] && s_ff.ctrl.sram_en) begin
      sram[10'(word_of(wb_adr_i))] <= wd;
    end
  end

  assign wb_dat_o = s_ff.dat;
  assign wb_ack_o = s_ff.ack;
  assign calib_o = s_ff.calib;
  assign alarm_evt_o = s_ff.alev;
  assign wakeup_evt_o = s_ff.wuev;
  assign stop_exit_o = s_ff.stop_x;
  assign standby_exit_o = s_ff.stby_x;
  assign mode_o = s_ff.mode;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sec_wrap: assert property (
    tick && !wr && s_ff.tm.sc == 7'(SEC_MAX) |=> s_ff.tm.sc == '0 && s_ff.sec)
    else $error("seconds did not wrap");
  a_feb_end: assert property (
    day_end && !wr && s_ff.dt.mo == 5'(MON_FEB) && s_ff.dt.dt == 6'(DAY_28)
    && !leap(s_ff.dt.yr) |=> s_ff.dt.dt == 6'(BCD_ONE) && s_ff.dt.mo != 5'(MON_FEB))
    else $error("february end missed");
  a_calib_off: assert property (
    !s_ff.ctrl.calib_en |=> !calib_o) else $error("calibration output while off");
  a_wut_reload: assert property (
    wck && s_ff.ctrl.wut_en && s_ff.wut_cnt == '0 |=> wakeup_evt_o && s_ff.wutf)
    else $error("wakeup timer did not fire");
  a_pre_default: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> s_ff.pre.asy == ASYNC_DEF && s_ff.pre.syn == SYNC_DEF)
    else $error("prescaler default wrong");
  a_sram_gate: assert property (
    req && !s_ff.ack && !wb_we_i && wb_adr_i[SRAM_BIT] && !s_ff.ctrl.sram_en
    |=> wb_ack_o && wb_dat_o == '0) else $error("sram readable while disabled");
  a_stop_exit: assert property (
    s_ff.mode == MD_STOP && |s_ff.s2.ext && !s_ff.s2.vbat
    |=> stop_exit_o && mode_o == MD_RUN) else $error("stop not ended");
  a_stby_exit: assert property (
    s_ff.mode == MD_STBY && rise.wkp && !s_ff.s2.vbat
    |=> standby_exit_o && mode_o == MD_RUN) else $error("standby not ended");
  a_batt_hold: assert property (
    s_ff.s2.vbat |=> !stop_exit_o && !standby_exit_o) else $error("woke on battery");
  c_alarm: cover property (alarm_evt_o[0] ##1 1'b1);
  c_wut: cover property (wakeup_evt_o);
  c_stop: cover property (stop_exit_o);
  c_stby: cover property (standby_exit_o);
endmodule

// File: design/rtcb_pkg.sv
/* rtcb_pkg: register map, field layouts, reset values, limits and types
   of the backup-domain calendar clock.
   assumes classic wishbone, 32-bit data, byte addresses, 100 MHz clk_i. */
// Behaviour
// - BCD calendar fields, 12 or 24 hour.
// - date rollover follows month length, leap years.
// - clock from crystal, RC, or fast/128.
// - 512 Hz calibration output available.
// - two alarms, each field maskable.
// - 16-bit reload wakeup downcounter, selectable resolution.
// - 20-bit prescaler, default one second tick.
// - optional 50/60 Hz reference paces seconds.
// - backup SRAM off until software enables.
// - backup words survive every reset.
// - alarms and wakeup end stop, standby.
// - any event line ends stop mode.
// - reset, watchdog, pin edge, calendar end standby.
// - calendar keeps counting in stop, standby.
// - standby keeps backup words, enabled SRAM only.
// - no wakeup while on battery supply.
package rtcb_pkg;
  // bus geometry
  localparam int AW = 13;
  localparam int BYTE_BITS = 2;
  localparam int SRAM_BIT = 12;
  localparam int BKP_WORDS = 20;
  localparam int SRAM_WORDS = 1024;
  // register byte offsets
  localparam logic [AW-1:0] OFS_TIME = 13'h0000;
  localparam logic [AW-1:0] OFS_DATE = 13'h0004;
  localparam logic [AW-1:0] OFS_CTRL = 13'h0008;
  localparam logic [AW-1:0] OFS_PRE = 13'h000C;
  localparam logic [AW-1:0] OFS_WUT = 13'h0010;
  localparam logic [AW-1:0] OFS_STAT = 13'h0014;
  localparam logic [AW-1:0] OFS_ALR0 = 13'h0018;
  localparam logic [AW-1:0] OFS_ALR1 = 13'h001C;
  localparam logic [AW-1:0] OFS_PWR = 13'h0020;
  localparam logic [AW-1:0] OFS_BKP = 13'h0100;
  localparam logic [AW-1:0] OFS_BKP_END = 13'h0150;
  // writable bits per register
  localparam logic [31:0] TIME_MASK = 32'h007F7F7F;
  localparam logic [31:0] DATE_MASK = 32'h00FFFF3F;
  localparam logic [31:0] ALRM_MASK = 32'hBFFFFFFF;
  localparam logic [31:0] CTRL_MASK = 32'h00000FFF;
  localparam logic [31:0] PRE_MASK = 32'h007F1FFF;
  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HR24_MAX = 8'h23;
  localparam logic [7:0] HR12_MAX = 8'h12;
  localparam logic [7:0] HR12_TURN = 8'h11;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] YR_MAX = 8'h99;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_31 = 8'h31;
  localparam logic [2:0] WD_MIN = 3'h1;
  localparam logic [2:0] WD_MAX = 3'h7;
  // time base
  localparam logic [6:0] HSE_DIV_LAST = 7'h7F; // divide by 128
  localparam logic [6:0] ASYNC_DEF = 7'h7F;
  localparam logic [12:0] SYNC_DEF = 13'h00FF;
  localparam int CAL_BIT = 5; // 512 Hz tap at default async
  localparam logic [5:0] REF_50 = 6'h32;
  localparam logic [5:0] REF_60 = 6'h3C;
  // wakeup resolution masks on the rtc clock divider
  localparam logic [3:0] WDV_16 = 4'hF;
  localparam logic [3:0] WDV_8 = 4'h7;
  localparam logic [3:0] WDV_2 = 4'h1;
  typedef enum logic [1:0] {CS_XTAL = 2'b00, CS_RC = 2'b01, CS_FAST = 2'b10} rtcb_clk_t;
  typedef enum logic [1:0] {WS_16 = 2'b00, WS_8 = 2'b01, WS_2 = 2'b10, WS_SEC = 2'b11} rtcb_ws_t;
  typedef enum logic [1:0] {MD_RUN = 2'b00, MD_STOP = 2'b01, MD_STBY = 2'b10} rtcb_mode_t;
  // register layouts
  typedef struct packed {
    logic [8:0] rsv; logic pm; logic [5:0] hr; logic z1;
    logic [6:0] mn; logic z0; logic [6:0] sc;
  } rtcb_time_reg_t;
  typedef struct packed {
    logic [7:0] rsv; logic [7:0] yr; logic [2:0] wd;
    logic [4:0] mo; logic [1:0] z0; logic [5:0] dt;
  } rtcb_date_reg_t;
  typedef struct packed {
    logic dmsk; logic z2; logic [5:0] dt; logic hmsk; logic pm;
    logic [5:0] hr; logic mmsk; logic [6:0] mn; logic smsk; logic [6:0] sc;
  } rtcb_alrm_reg_t;
  typedef struct packed {
    logic [19:0] rsv; logic [1:0] alrm_en; logic wut_en; logic [1:0] wut_sel;
    logic ref_60; logic ref_en; logic sram_en; logic calib_en; logic fmt12;
    logic [1:0] clk_sel;
  } rtcb_ctrl_reg_t;
  typedef struct packed {
    logic [8:0] rsv; logic [6:0] asy; logic [2:0] z0; logic [12:0] syn;
  } rtcb_pre_reg_t;
  typedef struct packed {
    logic [25:0] rsv; logic sram_ok; logic [1:0] mode; logic wutf; logic [1:0] alf;
  } rtcb_stat_reg_t;
  // pins, sampled as one group
  typedef struct packed {
    logic xtal; logic rc; logic fast; logic refc; logic wkp; logic rst_n;
    logic wdg; logic tamp; logic tstp; logic voltage_detector_output; logic usb; logic eth;
    logic vbat; logic [15:0] ext;
  } rtcb_pin_t;
  localparam rtcb_pre_reg_t PRE_RST = '{rsv: '0, asy: ASYNC_DEF, z0: '0, syn: SYNC_DEF};
  localparam rtcb_date_reg_t DATE_RST = '{rsv: '0, yr: '0, wd: WD_MIN, mo: 5'h01,
                                          z0: '0, dt: 6'h01};
endpackage

// File: design/rtcb_alarm.sv
/* rtcb_alarm: one alarm comparator with per-field masks.
   assumes sec_i pulses in the cycle after the calendar advanced. */
`timescale 1ns/100ps
module rtcb_alarm import rtcb_pkg::*; (
  input logic clk_i,
  input logic rst_i,
  input logic sec_i,
  input logic en_i,
  input rtcb_time_reg_t tm_i,
  input rtcb_date_reg_t dt_i,
  input rtcb_alrm_reg_t al_i,
  output logic hit_o
);
  // whole state of the comparator
  typedef struct packed {logic hit;} rtcb_alm_st_t;
  rtcb_alm_st_t st_ff, nxt_st;
  logic match; // all unmasked fields equal

  // compare, fire once per new second
  always_comb begin
    nxt_st = st_ff;
    match = (al_i.smsk || al_i.sc == tm_i.sc)
         && (al_i.mmsk || al_i.mn == tm_i.mn)
         && (al_i.hmsk || (al_i.hr == tm_i.hr && al_i.pm == tm_i.pm))
         && (al_i.dmsk || al_i.dt == dt_i.dt);
    nxt_st.hit = sec_i && en_i && match;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit_o = st_ff.hit;

  a_alarm_match: assert property (@(posedge clk_i) disable iff (rst_i)
    sec_i && en_i && match |=> hit_o) else $error("alarm missed a match");
  a_alarm_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sec_i && en_i) |=> !hit_o) else $error("alarm fired without a second");
  c_alarm_hit: cover property (@(posedge clk_i) disable iff (rst_i) hit_o);
endmodule

// File: dv/rtcb_far.sv
/* rtcb_far: crystal and wake sources facing the calendar clock.
   assumes sel_i and fire_i change just after a bench clock edge. */
`timescale 1ns/100ps
module rtcb_far (
  input logic [3:0] sel_i,
  input logic fire_i,
  output logic xtal_o,
  output logic [8:0] src_o
);
  // free-running crystal, 200 ns period keeps seconds short
  initial xtal_o = 1'b0;
  always #100 xtal_o = ~xtal_o;
  // one wake source active at a time
  always_comb begin
    src_o = '0;
    if (fire_i) src_o[sel_i] = 1'b1;
  end
endmodule

// File: dv/tb.sv
/* tb: calendar, backup store and wake paths against an integer model.
   assumes rtcb_far supplies the crystal and the wake sources. */
`timescale 1ns/100ps
module tb import rtcb_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, fire = 1'b0, bat = 1'b0;
  logic [12:0] adr = '0;
  logic [3:0] src = '0;
  logic [15:0] ext = 16'h0001;
  logic [31:0] wd = '0, rd, ex, dq, rnd = 32'hE343E610;
  logic [31:0] dates [5] = '{32'h00242228, 32'h00244229, 32'h00232228, 32'h0023E430,
                             32'h00997231};
  logic [31:0] bq [$];
  logic [8:0] wk;
  logic xtal, ack, sx, bx, cal, wev;
  logic [1:0] alm;
  rtcb_mode_t mode;
  int err_total = 0, checks_done = 0, cycles = 0, alarms = 0;
  int dd, mm, yy, wdy, n;
  localparam int RTC_CLKS = 20; // crystal period of the far model in clk cycles

  always #5 clk_i = ~clk_i;
  rtcb_far far (.sel_i(src), .fire_i(fire), .xtal_o(xtal), .src_o(wk));
  rtcb_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dq), .wb_ack_o(ack),
    .xtal_clk_i(xtal), .rc_clk_i(1'b0), .fast_external_oscillator_i(1'b0), .ref_clk_i(1'b0),
    .wakeup_pin_i(wk[5]), .external_reset_pin_n_i(~wk[6]), .independent_watchdog_rst_i(wk[7]),
    .tamper_i(wk[4]), .timestamp_i(wk[8]), .voltage_detector_output_i(wk[1]),
    .usb_wake_i(wk[2]), .eth_wake_i(wk[3]), .on_battery_i(bat),
    .external_event_lines_i(wk[0] ? ext : 16'h0000), .calib_o(cal), .alarm_evt_o(alm),
    .wakeup_evt_o(wev), .stop_exit_o(sx), .standby_exit_o(bx), .mode_o(mode));

  // integer calendar model helpers
  function automatic int b2i(input logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction
  function automatic logic [7:0] i2b(input int i);
    return 8'((i / 10) * 16 + i % 10);
  endfunction
  function automatic int mdays(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dq;
    cyc <= 1'b0;
  endtask
  task do_reset;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // cycle ceiling and alarm pulse count
  always @(posedge clk_i) begin
    cycles++;
    if (alm[0] === 1'b1) alarms++;
    if (cycles == 30000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    do_reset();
    // backup words across a reset, store still disabled
    for (int k = 0; k < BKP_WORDS; k++) begin
      rnd = lfsr(rnd);
      bq.push_back(rnd);
      bus(1'b1, OFS_BKP + 13'(4 * k), rnd);
    end
    bus(1'b1, 13'h1000, rnd);
    bus(1'b0, 13'h1000, '0);
    check("sram off", rd, '0);
    bus(1'b0, OFS_BKP_END, '0);
    check("unmapped", rd, '0);
    do_reset();
    for (int k = 0; k < BKP_WORDS; k++) begin
      bus(1'b0, OFS_BKP + 13'(4 * k), '0);
      check("backup", rd, bq[k]);
    end
    $display("test backup done");
    // rollover cases, hour format alternating, alarm on second zero
    bus(1'b1, OFS_PRE, 32'h00010001);
    bus(1'b1, OFS_ALR0, 32'h80808000);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_CTRL, 32'h410 | 32'(i % 2) << 2);
      bus(1'b1, OFS_DATE, dates[i]);
      ex = (i % 2) ? 32'h00515959 : 32'h00235959;
      bus(1'b1, OFS_TIME, ex);
      do bus(1'b0, OFS_TIME, '0); while (rd === ex);
      check("time", rd, (i % 2) ? 32'h00120000 : 32'h0);
      dd = b2i({2'b00, dates[i][5:0]});
      mm = b2i({3'b000, dates[i][12:8]});
      wdy = dates[i][15:13] % 7 + 1;
      yy = b2i(dates[i][23:16]);
      if (dd < mdays(mm, yy)) dd++;
      else begin
        dd = 1;
        mm = mm % 12 + 1;
        if (mm == 1) yy = (yy + 1) % 100;
      end
      bus(1'b0, OFS_DATE, '0);
      check("date", rd, 32'(i2b(yy)) << 16 | 32'(wdy) << 13 | 32'(i2b(mm)) << 8 | 32'(i2b(dd)));
      check("alarm", 32'(alarms), 32'(i + 1));
    end
    bus(1'b1, 13'h1000, 32'h5A5AC3C3);
    $display("test calendar done");
    // stop sources 0..4, standby sources 5..8
    for (int s = 0; s < 9; s++) begin
      bus(1'b1, OFS_PWR, (s < 5) ? 32'h1 : 32'h2);
      repeat (2) @(posedge clk_i);
      check("mode in", 32'(mode), (s < 5) ? 32'h1 : 32'h2);
      rnd = lfsr(rnd);
      ext <= rnd[15:0] | 16'h0001;
      src <= 4'(s);
      bat <= (s == 0);
      fire <= 1'b1;
      if (s == 0) begin
        repeat (10) @(posedge clk_i);
        check("battery", 32'(mode), 32'h1);
        bat <= 1'b0;
      end
      do @(posedge clk_i); while (sx !== 1'b1 && bx !== 1'b1);
      check("exit", {30'h0, bx, sx}, (s < 5) ? 32'h1 : 32'h2);
      check("run", 32'(mode), 32'h0);
      fire <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    bus(1'b0, OFS_BKP, '0);
    check("backup kept", rd, bq[0]);
    bus(1'b0, 13'h1000, '0);
    check("sram kept", rd, 32'h5A5AC3C3);
    $display("test power done");
    // wakeup period in units of two rtc clocks, then calibration half period
    rnd = lfsr(rnd);
    bus(1'b1, OFS_PRE, 32'(PRE_RST));
    bus(1'b1, OFS_WUT, 32'(rnd[3:0]));
    bus(1'b1, OFS_CTRL, 32'h718);
    do @(posedge clk_i); while (wev !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wev !== 1'b1);
    check("wakeup period", 32'(n), 32'((rnd[3:0] + 1) * 2 * RTC_CLKS));
    do @(posedge clk_i); while (cal !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cal === 1'b1);
    check("calib half period", 32'(n), 32'(32 * RTC_CLKS));
    $display("test timers done");
    stop_test();
  end
endmodule
